/* File: pkg/uedma_defines.svh */
`ifndef UEDMA_DEFINES_SVH
`define UEDMA_DEFINES_SVH

// ********************************************************
// Host-DMA protocol header layout
// ********************************************************
`define UEDMA_HDR_LAST      3'h4
`define UEDMA_HDR_CTRL      3'h0
`define UEDMA_HDR_ADDR0     3'h1
`define UEDMA_HDR_ADDR1     3'h2
`define UEDMA_HDR_ADDR2     3'h3
`define UEDMA_HDR_DIR_BIT   7
`define UEDMA_HDR_INT_BIT   6
`define UEDMA_HDR_BURST_HI  5

// ********************************************************
// Data buffer
// ********************************************************
`define UEDMA_BUF_ENTRIES   2'h2

`endif

/* File: pkg/uedma_pkg.sv */
package uedma_pkg;

    typedef enum logic [1:0] {
        UEDMA_NISO_OUT,
        UEDMA_ISO_IN,
        UEDMA_ISO_OUT
    } uedma_mode_t;

    typedef enum logic [1:0] {
        UEDMA_ZS_NORMAL,
        UEDMA_ZS_SHORT,
        UEDMA_ZS_IGNORE,
        UEDMA_ZS_MISSERR
    } uedma_zstat_t;

    typedef enum {
        UEDMA_S_IDLE,
        UEDMA_S_HDR,
        UEDMA_S_RUN,
        UEDMA_S_PAUSE,
        UEDMA_S_ZLP
    } uedma_state_t;

endpackage

/* File: verilog/uedma_seq.sv */
`timescale 1ns/10ps
`default_nettype none
`include "uedma_defines.svh"

// Contract
// - Non-iso OUT full packet, bytes left: update count, clear NAK, keep open.
// - Non-iso OUT short packet, bytes left: end, reload or clear go, update, NAK.
// - OUT exact fit with short, no concat: update, clear NAK, await zero packet.
// - OUT count zero, buffer holds data, no concat: end, clear go, overflow.
// - Concat and reload at completion: end, swap, keep go, update, continue.
// - Non-iso concat without reload, data left: end, clear go, update, pause.
// - Iso OUT empty buffer with stop: end, clear go and stop, update, NAK.
// - Iso transfer unfinished at frame start: end, clear go, set overflow.
// - Iso IN full buffer, bytes left, missing error: end, clear go, send.
// - Iso IN concat and reload, buffer not full: end, update, next transfer.
// - Iso IN done, full buffer, missing error: end, clear go, no send.
// - Iso IN short, no concat, full buffer: keep open, update, zero packet.
// - Iso OUT zero-packet wait: error ends, short finishes, ignore clears NAK.
// - Iso OUT exact fit with short, no concat: update, NAK, expect zero packet.
// - Host mode uses one OUT and one IN endpoint, seen as bulk.
// - Host transfer per packet; write data follows header, read data later.
// - Header byte one bit 7: zero writes memory, one reads memory.
// - Host endpoints stay reserved until software reset or device reset.
// - Header byte one bits 5 to 0 give count, 1 through 63.
// - Header byte one bit 6 requests a done interrupt at transfer end.
module uedma_seq #(
    parameter int DW = 8,
    parameter int AW = 24,
    parameter int CW = 16
)(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire uedma_pkg::uedma_mode_t mode,
    input  wire logic                   goSet,
    input  wire logic [CW-1:0]          sizeIn,
    input  wire logic [AW-1:0]          addrIn,
    input  wire logic                   reloadSet,
    input  wire logic [CW-1:0]          reloadSize,
    input  wire logic [AW-1:0]          reloadAddr,
    input  wire logic                   stopSet,
    input  wire logic                   concatReq,
    input  wire logic                   shortReq,
    input  wire logic                   overflowClr,
    input  wire logic                   missingIsError,
    input  wire logic                   prevMissed,
    input  wire logic                   pktEvt,
    input  wire logic                   pktMax,
    input  wire uedma_pkg::uedma_zstat_t zeroLenStatus,
    input  wire logic                   epEmpty,
    input  wire logic                   epFull,
    input  wire logic                   sofEvt,
    input  wire logic                   hostEnable,
    input  wire logic                   softReset,
    input  wire logic                   srcValid,
    input  wire logic [DW-1:0]          srcData,
    output logic                        srcReady,
    output logic                        sinkValid,
    output logic [DW-1:0]               sinkData,
    input  wire logic                   sinkReady,
    output logic [AW-1:0]               memAddr,
    output logic                        readDir,
    output logic                        xferGo,
    output logic                        stopReq,
    output logic                        reloadPending,
    output logic                        overflowFlag,
    output logic                        nakClr,
    output logic                        sendPkt,
    output logic                        sendZero,
    output logic                        cntUpd,
    output logic [CW-1:0]               dmaCount,
    output logic                        hostReserved,
    output logic                        hostDone
);

    // ********************************************************
    // State
    // ********************************************************
    uedma_pkg::uedma_state_t state_reg;
    uedma_pkg::uedma_state_t state_next;
    logic [CW-1:0] left_reg;
    logic [CW-1:0] left_next;
    logic [CW-1:0] bytes_reg;
    logic [2:0]    hdrIdx_reg;
    logic          intReq_reg;
    logic [DW-1:0] spare_reg;
    logic          spareValid_reg;
    logic [1:0]    fill_next;
    logic          take;
    logic          push;
    logic          pop;
    logic          load;
    logic          hdrDone;
    logic          done;
    logic          missErr;
    logic          endX, fin, swap, clrGo, clrStp, setOvf, upd, nak, snd, zero, toZlp, toPause;

    assign take    = srcValid & srcReady;
    assign push    = take & (state_reg == uedma_pkg::UEDMA_S_RUN);
    assign pop     = sinkValid & sinkReady;
    assign done    = (left_reg == '0);
    assign missErr = missingIsError & prevMissed;
    assign hdrDone = take & (state_reg == uedma_pkg::UEDMA_S_HDR) & (hdrIdx_reg == `UEDMA_HDR_LAST);
    assign load    = goSet & ~hostReserved & (state_reg == uedma_pkg::UEDMA_S_IDLE);

    // ********************************************************
    // Transfer state decisions
    // ********************************************************
    always_comb
    begin
        {endX, fin, clrGo, clrStp, setOvf, upd, nak, snd, zero, toZlp, toPause} = '0;
        if (hostReserved)
        begin
            fin = 1'h0;
        end
        else if (state_reg == uedma_pkg::UEDMA_S_ZLP && pktEvt)
        begin
            if (mode == uedma_pkg::UEDMA_ISO_OUT)
            begin
                case (zeroLenStatus)
                    uedma_pkg::UEDMA_ZS_MISSERR:
                    begin
                        endX = 1'h1;
                        clrGo = 1'h1;
                        upd = 1'h1;
                        nak = 1'h1;
                    end
                    uedma_pkg::UEDMA_ZS_SHORT:
                    begin
                        fin = 1'h1;
                        upd = 1'h1;
                        nak = 1'h1;
                    end
                    uedma_pkg::UEDMA_ZS_IGNORE: nak = 1'h1;
                    default: nak = 1'h0;
                endcase
            end
            else
            begin
                fin = ~pktMax | (mode == uedma_pkg::UEDMA_ISO_IN);
                nak = fin & (mode == uedma_pkg::UEDMA_NISO_OUT);
            end
        end
        else if (state_reg == uedma_pkg::UEDMA_S_RUN && (pktEvt || done || sofEvt))
        begin
            if (mode != uedma_pkg::UEDMA_NISO_OUT && sofEvt && !done)
            begin
                endX = 1'h1;
                clrGo = 1'h1;
                setOvf = 1'h1;
            end
            else if (mode == uedma_pkg::UEDMA_ISO_IN)
            begin
                if (stopReq && (done || (epFull && pktEvt)))
                begin
                    endX = 1'h1;
                    clrGo = 1'h1;
                    clrStp = 1'h1;
                    upd = epFull;
                    snd = epFull;
                end
                else if (epFull && !done && pktEvt)
                begin
                    endX = missErr;
                    clrGo = missErr;
                    upd = ~missErr;
                    snd = 1'h1;
                end
                else if (!epFull && done)
                begin
                    endX = 1'h1;
                    upd = 1'h1;
                    fin = concatReq & reloadPending;
                    clrGo = ~fin;
                    setOvf = concatReq & ~reloadPending;
                    snd = ~fin;
                end
                else if (epFull && done)
                begin
                    if (missErr)
                    begin
                        endX = 1'h1;
                        clrGo = 1'h1;
                    end
                    else if (shortReq && !concatReq)
                    begin
                        upd = 1'h1;
                        zero = 1'h1;
                        toZlp = 1'h1;
                    end
                    else
                    begin
                        fin = 1'h1;
                        upd = 1'h1;
                        snd = 1'h1;
                    end
                end
            end
            else
            begin
                if (stopReq && (epEmpty || done))
                begin
                    endX = 1'h1;
                    clrGo = 1'h1;
                    clrStp = 1'h1;
                    upd = epEmpty;
                    nak = epEmpty | (mode == uedma_pkg::UEDMA_ISO_OUT);
                end
                else if (epEmpty && !done && pktEvt)
                begin
                    if (mode == uedma_pkg::UEDMA_ISO_OUT)
                    begin
                        nak = 1'h1;
                        upd = (zeroLenStatus != uedma_pkg::UEDMA_ZS_IGNORE);
                        fin = (zeroLenStatus == uedma_pkg::UEDMA_ZS_SHORT);
                        endX = (zeroLenStatus == uedma_pkg::UEDMA_ZS_MISSERR);
                        clrGo = endX;
                    end
                    else
                    begin
                        upd = 1'h1;
                        nak = 1'h1;
                        fin = ~pktMax;
                    end
                end
                else if (epEmpty && done)
                begin
                    upd = 1'h1;
                    nak = 1'h1;
                    toZlp = shortReq & ~concatReq & (pktMax | (mode == uedma_pkg::UEDMA_ISO_OUT));
                    fin = ~toZlp;
                end
                else if (!epEmpty && done)
                begin
                    endX = 1'h1;
                    upd = 1'h1;
                    fin = concatReq & reloadPending;
                    clrGo = ~fin;
                    setOvf = ~concatReq | (mode == uedma_pkg::UEDMA_ISO_OUT & ~reloadPending);
                    toPause = concatReq & ~reloadPending & (mode == uedma_pkg::UEDMA_NISO_OUT);
                    nak = (mode == uedma_pkg::UEDMA_ISO_OUT) & ~fin;
                end
            end
        end
        else if (state_reg == uedma_pkg::UEDMA_S_PAUSE && reloadPending)
        begin
            fin = 1'h1;
        end
        endX = endX | fin;
        swap = fin & reloadPending;
        clrGo = clrGo | (fin & ~reloadPending);
    end

    always_comb
    begin
        state_next = state_reg;
        left_next = left_reg;
        if (take && left_reg != '0 && state_reg == uedma_pkg::UEDMA_S_RUN)
        begin
            left_next = left_reg - CW'(1);
        end
        case (state_reg)
            uedma_pkg::UEDMA_S_IDLE:
            begin
                if (load)
                begin
                    state_next = uedma_pkg::UEDMA_S_RUN;
                    left_next = sizeIn;
                end
                else if (hostReserved && take)
                begin
                    state_next = uedma_pkg::UEDMA_S_HDR;
                end
            end
            uedma_pkg::UEDMA_S_HDR:
            begin
                if (hdrDone)
                begin
                    state_next = uedma_pkg::UEDMA_S_RUN;
                    left_next = CW'(bytes_reg[`UEDMA_HDR_BURST_HI:0]);
                end
            end
            uedma_pkg::UEDMA_S_RUN,
            uedma_pkg::UEDMA_S_PAUSE,
            uedma_pkg::UEDMA_S_ZLP:
            begin
                if (hostReserved && state_reg == uedma_pkg::UEDMA_S_RUN && done)
                begin
                    state_next = uedma_pkg::UEDMA_S_IDLE;
                end
                else if (swap)
                begin
                    state_next = uedma_pkg::UEDMA_S_RUN;
                    left_next = reloadSize;
                end
                else if (toPause)
                begin
                    state_next = uedma_pkg::UEDMA_S_PAUSE;
                end
                else if (endX)
                begin
                    state_next = uedma_pkg::UEDMA_S_IDLE;
                end
                else if (toZlp)
                begin
                    state_next = uedma_pkg::UEDMA_S_ZLP;
                end
            end
            default: state_next = uedma_pkg::UEDMA_S_IDLE;
        endcase
        fill_next = 2'(sinkValid) + 2'(spareValid_reg) + 2'(push) - 2'(pop);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= uedma_pkg::UEDMA_S_IDLE;
            left_reg <= '0;
            srcReady <= 1'h0;
        end
        else
        begin
            state_reg <= state_next;
            left_reg <= left_next;
            // Ready only when a word can land, so no word is dropped under stall
            srcReady <= (state_next == uedma_pkg::UEDMA_S_HDR)
                      | (state_next == uedma_pkg::UEDMA_S_IDLE & hostReserved & ~softReset)
                      | (state_next == uedma_pkg::UEDMA_S_RUN & fill_next < `UEDMA_BUF_ENTRIES
                         & left_next != '0);
        end
    end

    // ********************************************************
    // Host header capture
    // ********************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hdrIdx_reg <= '0;
            bytes_reg <= '0;
            intReq_reg <= 1'h0;
            readDir <= 1'h0;
            hostReserved <= 1'h0;
            hostDone <= 1'h0;
        end
        else
        begin
            hostReserved <= ~softReset & (hostReserved | hostEnable);
            hostDone <= hostReserved & intReq_reg & done
                      & (state_reg == uedma_pkg::UEDMA_S_RUN);
            if (take && state_reg != uedma_pkg::UEDMA_S_RUN)
            begin
                hdrIdx_reg <= hdrDone ? `UEDMA_HDR_CTRL : hdrIdx_reg + 3'h1;
                if (hdrIdx_reg == `UEDMA_HDR_CTRL)
                begin
                    bytes_reg <= CW'(srcData);
                    readDir <= srcData[`UEDMA_HDR_DIR_BIT];
                    intReq_reg <= srcData[`UEDMA_HDR_INT_BIT];
                end
            end
            else if (state_reg == uedma_pkg::UEDMA_S_IDLE)
            begin
                hdrIdx_reg <= `UEDMA_HDR_CTRL;
            end
            if (load || swap || hdrDone)
            begin
                bytes_reg <= '0;
            end
            else if (push)
            begin
                bytes_reg <= bytes_reg + CW'(1);
            end
        end
    end

    // ********************************************************
    // Address and control bits
    // ********************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            memAddr <= '0;
            xferGo <= 1'h0;
            stopReq <= 1'h0;
            reloadPending <= 1'h0;
            overflowFlag <= 1'h0;
        end
        else
        begin
            if (load)
            begin
                memAddr <= addrIn;
            end
            else if (swap)
            begin
                memAddr <= reloadAddr;
            end
            else if (take && state_reg != uedma_pkg::UEDMA_S_RUN)
            begin
                case (hdrIdx_reg)
                    `UEDMA_HDR_ADDR0: memAddr[7:0] <= srcData;
                    `UEDMA_HDR_ADDR1: memAddr[15:8] <= srcData;
                    `UEDMA_HDR_ADDR2: memAddr[23:16] <= srcData;
                    default: memAddr <= memAddr;
                endcase
            end
            else if (push)
            begin
                memAddr <= memAddr + AW'(1);
            end
            // Hardware sets win over the clears in the same cycle
            xferGo <= load | hdrDone | (xferGo & ~clrGo
                      & ~(hostReserved & done & state_reg == uedma_pkg::UEDMA_S_RUN));
            stopReq <= stopSet | (stopReq & ~clrStp);
            reloadPending <= reloadSet | (reloadPending & ~swap);
            overflowFlag <= setOvf | (overflowFlag & ~overflowClr);
        end
    end

    // ********************************************************
    // Endpoint pulses and count
    // ********************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            nakClr <= 1'h0;
            sendPkt <= 1'h0;
            sendZero <= 1'h0;
            cntUpd <= 1'h0;
            dmaCount <= '0;
        end
        else
        begin
            nakClr <= nak;
            sendPkt <= snd;
            sendZero <= zero;
            cntUpd <= upd;
            if (load)
            begin
                dmaCount <= '0;
            end
            else if (upd)
            begin
                dmaCount <= bytes_reg;
            end
        end
    end

    // ********************************************************
    // Two-entry data buffer
    // ********************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sinkValid <= 1'h0;
            sinkData <= '0;
            spareValid_reg <= 1'h0;
            spare_reg <= '0;
        end
        else if (pop)
        begin
            if (spareValid_reg)
            begin
                sinkData <= spare_reg;
                spareValid_reg <= push;
                spare_reg <= srcData;
            end
            else
            begin
                sinkValid <= push;
                sinkData <= srcData;
            end
        end
        else if (push)
        begin
            if (!sinkValid)
            begin
                sinkValid <= 1'h1;
                sinkData <= srcData;
            end
            else
            begin
                spareValid_reg <= 1'h1;
                spare_reg <= srcData;
            end
        end
    end

endmodule

`default_nettype wire

/* File: bench/uedma_seq_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// Checker on the sequencer's ports
// ********
module uedma_seq_monitor #(
    parameter int AW = 24,
    parameter int DW = 8
)(
    input wire logic                   clk,
    input wire logic                   rst,
    input wire uedma_pkg::uedma_mode_t mode,
    input wire logic                   sofEvt,
    input wire logic                   softReset,
    input wire logic                   srcValid,
    input wire logic                   srcReady,
    input wire logic                   sinkValid,
    input wire logic [DW-1:0]          sinkData,
    input wire logic                   sinkReady,
    input wire logic [AW-1:0]          memAddr,
    input wire logic                   xferGo,
    input wire logic                   stopReq,
    input wire logic                   overflowFlag,
    input wire logic                   nakClr,
    input wire logic                   cntUpd,
    input wire logic                   hostReserved,
    input wire logic                   hostDone
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    stop_done_a: assert property ($fell(stopReq) |-> !xferGo)
        else $error("stop dropped early");
    sof_overflow_a: assert property (xferGo && srcReady && sofEvt
        && mode != uedma_pkg::UEDMA_NISO_OUT |=> overflowFlag && !xferGo)
        else $error("late frame not ended");
    ovf_no_nak_a: assert property ($rose(overflowFlag)
        && mode == uedma_pkg::UEDMA_NISO_OUT |-> !nakClr)
        else $error("overflow cleared nak");
    count_pulse_a: assert property (cntUpd |=> !cntUpd)
        else $error("count pulse too long");
    sink_hold_a: assert property (sinkValid && !sinkReady
        |=> sinkValid && $stable(sinkData))
        else $error("sink word lost");
    push_sink_a: assert property (srcValid && srcReady && xferGo |=> sinkValid)
        else $error("byte not offered");
    addr_step_a: assert property (srcValid && srcReady && xferGo
        |=> memAddr == $past(memAddr) + 1'b1)
        else $error("address did not step");
    host_keep_a: assert property (hostReserved && !softReset |=> hostReserved)
        else $error("host released early");
    host_done_a: assert property (hostDone |-> !xferGo && hostReserved)
        else $error("host done too early");
    cover property ($rose(overflowFlag));
    cover property ($fell(stopReq));
    cover property (hostDone);
endmodule
bind uedma_seq uedma_seq_monitor #(.AW(AW), .DW(DW)) u_mon (.clk, .rst, .mode, .sofEvt,
    .softReset, .srcValid, .srcReady, .sinkValid, .sinkData, .sinkReady, .memAddr,
    .xferGo, .stopReq, .overflowFlag, .nakClr, .cntUpd, .hostReserved, .hostDone);
`default_nettype wire

/* File: bench/uedma_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// Host and endpoint side
// ********
module uedma_far_end (
    input  wire logic       clk,
    input  wire logic       srcReady,
    input  wire logic       sinkValid,
    input  wire logic [7:0] sinkData,
    output logic            srcValid,
    output logic [7:0]      srcData,
    output logic            sinkReady
);
    logic [7:0] q[$];
    logic [7:0] got[$];
    logic       taken;
    integer     seed = 32'he83fab7c;
    // Write data follows the header
    task automatic header(input logic rd, input logic irq, input logic [5:0] n,
                          input logic [23:0] a);
        q.push_back({rd, irq, n});
        q.push_back(a[7:0]);
        q.push_back(a[15:8]);
        q.push_back(a[23:16]);
        q.push_back(8'h00);
    endtask
    initial
    begin
        srcValid = 1'b0;
        srcData = 8'h00;
        sinkReady = 1'b1;
        taken = 1'b0;
    end
    always @(posedge clk)
    begin
        taken <= srcValid && srcReady;
        if (sinkValid && sinkReady)
            got.push_back(sinkData);
    end
    // Idle data is inverted so a stale byte never looks valid
    always @(negedge clk)
    begin
        if (taken)
            void'(q.pop_front());
        srcValid <= q.size() > 0;
        srcData <= (q.size() > 0) ? q[0] : ~srcData;
        sinkReady <= ($random(seed) & 3) != 0;
    end
endmodule
`default_nettype wire

/* File: bench/uedma_seq_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module uedma_seq_bench;
    logic                    clk, rst, goSet, reloadSet, stopSet, concatReq, shortReq;
    logic                    overflowClr, missingIsError, prevMissed, pktEvt, pktMax;
    logic                    epEmpty, epFull, sofEvt, hostEnable, softReset, srcValid;
    logic                    srcReady, sinkValid, sinkReady, readDir, xferGo, stopReq;
    logic                    reloadPending, overflowFlag, nakClr, sendPkt, sendZero;
    logic                    cntUpd, hostReserved, hostDone, snd, cnt, hd;
    logic [7:0]              srcData, sinkData;
    logic [15:0]             sizeIn, reloadSize, dmaCount;
    logic [23:0]             addrIn, reloadAddr, memAddr, a;
    uedma_pkg::uedma_mode_t  mode;
    uedma_pkg::uedma_zstat_t zeroLenStatus;
    logic [7:0]              sent[$];
    integer                  seed = 32'he83fab7c;
    int                      nMismatch, testsRun, cyc;
    uedma_seq u_dut (.*);
    uedma_far_end u_far (.clk, .srcReady, .sinkValid, .sinkData, .srcValid, .srcData,
        .sinkReady);
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        snd <= snd | nakClr | sendPkt | sendZero;
        cnt <= cnt | cntUpd;
        hd <= hd | hostDone;
        cyc++;
        if (cyc == 20000)
        begin
            nMismatch++;
            conclude();
        end
    end
    // ********
    // Shared tasks
    // ********
    task automatic conclude();
        if (nMismatch == 0 && testsRun > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic restart();
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        sent.delete();
        u_far.got.delete();
        {snd, cnt, hd} = 3'h0;
    endtask
    task automatic push(input int n);
        logic [7:0] b;
        repeat (n)
        begin
            b = 8'($random(seed));
            sent.push_back(b);
            u_far.q.push_back(b);
        end
        for (int i = 0; i < 60 && u_far.q.size() > 0; i++)
            @(negedge clk);
        repeat (8)
            @(negedge clk);
        foreach (sent[i])
            chk("sinkData", u_far.got[i], sent[i]);
    endtask
    // Nibbles: mode, size, stop/reload/concat/short, max/empty/full/missing, pkt/sof, zls, expect
    task automatic sc(input logic [27:0] v);
        restart();
        mode = uedma_pkg::uedma_mode_t'(v[25:24]);
        {concatReq, shortReq} = v[17:16];
        {pktMax, epEmpty, epFull, missingIsError} = v[15:12];
        prevMissed = v[12];
        zeroLenStatus = uedma_pkg::uedma_zstat_t'(v[5:4]);
        sizeIn = 16'(v[23:20]);
        addrIn = 24'($random(seed));
        reloadAddr = 24'($random(seed));
        goSet = 1'b1;
        @(negedge clk);
        {goSet, stopSet, reloadSet} = {1'b0, v[19:18]};
        @(negedge clk);
        {stopSet, reloadSet} = 2'h0;
        push(2);
        {pktEvt, sofEvt} = v[9:8];
        @(negedge clk);
        {pktEvt, sofEvt} = 2'h0;
        repeat (6)
            @(negedge clk);
        chk("xferGo", xferGo, 32'(v[3]));
        chk("overflowFlag", overflowFlag, 32'(v[2]));
        chk("send", snd, 32'(v[1]));
        chk("count", cnt, 32'(v[0]));
        chk("dmaCount", dmaCount, 32'({v[0], 1'b0}));
        chk("stopReq", stopReq, 32'h0);
    endtask
    // ********
    // Main sequence
    // ********
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {goSet, reloadSet, stopSet, concatReq, shortReq, overflowClr, pktEvt} = 7'h0;
        {missingIsError, prevMissed, pktMax, epEmpty, epFull, sofEvt} = 6'h0;
        {hostEnable, softReset, sizeIn, addrIn, reloadAddr} = '0;
        reloadSize = 16'h0008;
        mode = uedma_pkg::UEDMA_NISO_OUT;
        zeroLenStatus = uedma_pkg::UEDMA_ZS_NORMAL;
        repeat (16)
            @(negedge clk);
        sc(28'h040c20b);
        sc(28'h0404203);
        sc(28'h044420b);
        sc(28'h021c00b);
        sc(28'h0208005);
        sc(28'h0268009);
        sc(28'h0228001);
        sc(28'h228c003);
        sc(28'h1400104);
        sc(28'h1403202);
        sc(28'h1260009);
        sc(28'h1203000);
        sc(28'h121200b);
        sc(28'h221c00b);
        sc(28'h221c22b);
        sc(28'h221c233);
        sc(28'h221c213);
        restart();
        hostEnable = 1'b1;
        @(negedge clk);
        hostEnable = 1'b0;
        a = 24'($random(seed));
        u_far.header(1'b0, 1'b1, 6'h02, a);
        push(2);
        chk("hostDone", hd, 32'h1);
        chk("readDir", readDir, 32'h0);
        chk("memAddr", memAddr, a + 24'h2);
        u_far.header(1'b1, 1'b0, 6'h01, a);
        push(0);
        chk("readDir", readDir, 32'h1);
        chk("hostReserved", hostReserved, 32'h1);
        softReset = 1'b1;
        @(negedge clk);
        softReset = 1'b0;
        @(negedge clk);
        chk("hostReserved", hostReserved, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
